// >>> alarm_monitor.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module alarm_monitor
  import alarm_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire meas_s       meas,
  input  wire logic        gen_req,
  input  wire logic [3:0]  reg_bank,
  input  wire logic [6:0]  alarm_open,
  input  wire logic        rx232_space,
  input  wire logic        rx485_space,
  output logic             tx232,
  output logic             tx485_d,
  output logic             tx485_oe,
  output logic [3:0]       bank_on,
  output logic             test_busy,
  output logic [5:0]       relay_on,
  output logic [5:0]       alarm_led,
  output logic [6:0]       input_led
);
  logic [24:0] tick_cnt_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [5:0]  site_q;
  logic [15:0] gen_v_q;
  logic [15:0] abs_v_q;
  logic [15:0] boost_q;
  logic [2:0]  wdog_q;
  logic [9:0]  period_q;
  alarm_s      alm_q;
  alarm_s      alm_d;
  test_state_e ts_q;
  test_state_e ts_d;
  logic [1:0]  idx_q;
  logic [1:0]  settle_q;
  logic [15:0] pre_q;
  logic        fail_q;
  logic        fail_d;

  // One-second tick
  wire tick = (tick_cnt_q == 25'(TICK_LEN - 1));

  always_ff @(posedge mclk) begin
    if (!nrst || tick) begin
      tick_cnt_q <= 25'h000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 25'h000_0001;
    end
  end

  // Avalon-MM slave: one wait cycle per access
  wire req      = read | write;
  wire wr_en    = write & ack_q;
  wire sel_ctrl = (address == REG_CTRL);
  wire sel_site = (address == REG_SITE);
  wire sel_gen  = (address == REG_GEN_V);
  wire sel_abs  = (address == REG_ABS_V);
  wire sel_bst  = (address == REG_BOOST);
  wire sel_stat = (address == REG_STATUS);
  wire refresh  = wr_en & sel_ctrl & writedata[CTRL_REFRESH_BIT];
  wire kick     = wr_en & sel_ctrl & writedata[CTRL_TEST_BIT];
  wire [6:0] in_byte = alarm_open;
  wire [31:0] status_word =
    {15'h0000, test_busy, 1'b0, in_byte, 2'b00, alm_q};
  wire [31:0] rd_mux =
    sel_site ? {26'h000_0000, site_q} :
    sel_gen  ? {16'h0000, gen_v_q} :
    sel_abs  ? {16'h0000, abs_v_q} :
    sel_bst  ? {16'h0000, boost_q} :
    sel_stat ? status_word : 32'h0000_0000;

  assign waitrequest = req & ~ack_q;
  assign readdata    = rdata_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      site_q  <= SITE_RST;
      gen_v_q <= GEN_V_RST;
      abs_v_q <= ABS_V_RST;
      boost_q <= BOOST_RST;
    end else if (wr_en) begin
      if (sel_site) begin
        site_q <= writedata[5:0];
      end else if (sel_gen) begin
        gen_v_q <= writedata[15:0];
      end else if (sel_abs) begin
        abs_v_q <= writedata[15:0];
      end else if (sel_bst) begin
        boost_q <= writedata[15:0];
      end
    end
  end

  // Refresh watchdog: software must write within the window
  wire healthy = (wdog_q < 3'(WDOG_TICKS));

  always_ff @(posedge mclk) begin
    if (!nrst || refresh) begin
      wdog_q <= 3'h0;
    end else if (tick && healthy) begin
      wdog_q <= wdog_q + 3'h1;
    end
  end

  // Voltage alarms
  wire [16:0] batt = {1'b0, meas.batt};
  wire [16:0] load = {1'b0, meas.load};
  wire [16:0] chg  = {1'b0, meas.chg};
  wire low_set  = (batt + LOW_ON) < {1'b0, gen_v_q};
  wire low_clr  = (batt + LOW_OFF) >= {1'b0, gen_v_q};
  wire high_set = batt > ({1'b0, abs_v_q} + HIGH_ON);
  wire high_clr = batt < ({1'b0, boost_q} + HIGH_OFF);
  wire load_sag = ((load + LOAD_DROP) < batt) && (batt < BATT_LIMIT);
  wire load_off = load < DISC_V;

  always_comb begin
    alm_d            = alm_q;
    alm_d.low_batt   = low_set | (alm_q.low_batt & ~low_clr);
    alm_d.high_batt  = high_set | (alm_q.high_batt & ~high_clr);
    alm_d.gen        = gen_req;
    alm_d.logic_fail = ~healthy;
    alm_d.load       = load_sag | load_off;
    if (ts_q != TS_IDLE && ts_d == TS_IDLE) begin
      alm_d.bank_fail = fail_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      alm_q <= '0;
    end else begin
      alm_q <= alm_d;
    end
  end

  // Bank test sequencer
  wire test_due = tick && (period_q == 10'(TEST_TICKS - 1));
  wire settled  = tick && (settle_q == 2'(SETTLE_TICKS - 1));
  wire stuck_on = chg > STUCK_I;
  wire bank_low = chg <= BANK_MIN_I;
  wire big_chg  = {1'b0, pre_q} > OC_MIN_I;

  always_ff @(posedge mclk) begin
    if (!nrst || test_due) begin
      period_q <= 10'h000;
    end else if (tick) begin
      period_q <= period_q + 10'h001;
    end
  end

  always_comb begin
    ts_d   = ts_q;
    fail_d = fail_q;
    case (ts_q)
      TS_IDLE: begin
        if (test_due || kick) begin
          ts_d   = TS_OFF;
          fail_d = 1'b0;
        end
      end
      TS_OFF: begin
        if (settled) begin
          fail_d = stuck_on;
          ts_d   = big_chg ? TS_ONE : TS_IDLE;
        end
      end
      TS_ONE: begin
        if (settled) begin
          fail_d = fail_q | bank_low;
          if (idx_q == 2'h3) begin
            ts_d = TS_IDLE;
          end
        end
      end
      default: begin
        ts_d = TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ts_q   <= TS_IDLE;
      fail_q <= 1'b0;
      pre_q  <= 16'h0000;
    end else begin
      ts_q   <= ts_d;
      fail_q <= fail_d;
      if (ts_q == TS_IDLE) begin
        pre_q <= meas.chg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || ts_q == TS_IDLE) begin
      idx_q    <= 2'h0;
      settle_q <= 2'h0;
    end else if (settled) begin
      settle_q <= 2'h0;
      if (ts_q == TS_ONE) begin
        idx_q <= idx_q + 2'h1;
      end
    end else if (tick) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  wire [3:0] one_bank = 4'h1 << idx_q;
  wire [3:0] test_pat = (ts_q == TS_ONE) ? one_bank : 4'h0;

  assign test_busy = (ts_q != TS_IDLE);
  assign bank_on   = test_busy ? test_pat : reg_bank;

  // Relays fail safe; logic-fail lamp reads inverted
  assign relay_on  = ~alm_q;
  assign alarm_led = alm_q ^ LED_INVERT;
  assign input_led = alarm_open;

  serial_slave u_serial (
    .mclk        (mclk),
    .nrst        (nrst),
    .site        (site_q),
    .out_byte    ({2'b00, alm_q}),
    .in_byte     ({1'b0, in_byte}),
    .rx232_space (rx232_space),
    .rx485_space (rx485_space),
    .tx232       (tx232),
    .tx485_d     (tx485_d),
    .tx485_oe    (tx485_oe)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic_lamp_a : assert property (
    alarm_led[3] == relay_on[3])
    else $error("Logic lamp sense wrong");
  wdog_drop_a : assert property (
    wdog_q == 3'(WDOG_TICKS) |=> !relay_on[3])
    else $error("Logic relay stays on after timeout");
  load_sag_a : assert property (
    load_sag |=> !relay_on[4])
    else $error("Load sag not alarmed");
  load_off_a : assert property (
    load_off |=> alm_q.load)
    else $error("Load disconnect not alarmed");
  bank_hold_a : assert property (
    ts_q == TS_IDLE && $past(ts_q) == TS_IDLE |-> $stable(alm_q.bank_fail))
    else $error("Bank alarm changed between tests");
  all_off_a : assert property (
    ts_q == TS_OFF |-> bank_on == 4'h0)
    else $error("Banks on during stuck test");
  stuck_hit_a : assert property (
    ts_q == TS_OFF && settled && stuck_on |=> fail_q)
    else $error("Stuck bank missed");
  skip_oc_a : assert property (
    ts_q == TS_OFF && settled && !big_chg |=> ts_q == TS_IDLE)
    else $error("Open test not skipped");
  one_bank_a : assert property (
    ts_q == TS_ONE |-> $onehot(bank_on))
    else $error("Not exactly one bank on");
  four_banks_a : assert property (
    ts_q == TS_ONE && settled && idx_q != 2'h3 |=> ts_q == TS_ONE)
    else $error("Test ended before bank four");
  give_back_a : assert property (
    !test_busy |-> bank_on == reg_bank)
    else $error("Regulator not in control");
  low_set_a : assert property (
    low_set |=> !relay_on[0])
    else $error("Low battery not alarmed");
  high_set_a : assert property (
    high_set |=> alm_q.high_batt)
    else $error("High battery not alarmed");

  stuck_c : cover property (ts_q == TS_OFF && settled && stuck_on);
  last_bank_c : cover property (ts_q == TS_ONE && idx_q == 2'h3);
  bank_fail_c : cover property ($rose(alm_q.bank_fail));
endmodule

// >>> alarm_pkg.sv
package alarm_pkg;
  // Time base
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TICK_S          = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;
  localparam int unsigned TEST_PERIOD_MIN = 15;
  localparam int unsigned TEST_TICKS      = TEST_PERIOD_MIN * 60 / TICK_S;
  localparam int unsigned SETTLE_S        = 2;
  localparam int unsigned SETTLE_TICKS    = SETTLE_S / TICK_S;
  localparam int unsigned WDOG_S          = 4;
  localparam int unsigned WDOG_TICKS      = WDOG_S / TICK_S;
  localparam int unsigned BAUD            = 9600;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYCLES     = BIT_CYCLES / 2;

  // Analog words: 10 mV and 10 mA per count
  localparam logic [16:0] LOAD_DROP  = 17'h0_00C8;
  localparam logic [16:0] BATT_LIMIT = 17'h0_1388;
  localparam logic [16:0] DISC_V     = 17'h0_0C80;
  localparam logic [16:0] STUCK_I    = 17'h0_01C2;
  localparam logic [16:0] OC_MIN_I   = 17'h0_0384;
  localparam logic [16:0] BANK_MIN_I = 17'h0_003C;
  localparam logic [16:0] LOW_ON     = 17'h0_0050;
  localparam logic [16:0] LOW_OFF    = 17'h0_0028;
  localparam logic [16:0] HIGH_ON    = 17'h0_0050;
  localparam logic [16:0] HIGH_OFF   = 17'h0_0028;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SITE   = 8'h04;
  localparam logic [7:0] REG_GEN_V  = 8'h08;
  localparam logic [7:0] REG_ABS_V  = 8'h0C;
  localparam logic [7:0] REG_BOOST  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int unsigned CTRL_REFRESH_BIT = 0;
  localparam int unsigned CTRL_TEST_BIT    = 1;
  localparam logic [15:0] GEN_V_RST  = 16'h12C0;
  localparam logic [15:0] ABS_V_RST  = 16'h170C;
  localparam logic [15:0] BOOST_RST  = 16'h15E0;
  localparam logic [5:0]  SITE_RST   = 6'h00;
  localparam logic [5:0]  LED_INVERT = 6'h08;
  localparam logic [7:0]  SITE_CMD   = 8'hC0;

  typedef struct packed {
    logic bank_fail;
    logic load;
    logic logic_fail;
    logic gen;
    logic high_batt;
    logic low_batt;
  } alarm_s;

  typedef struct packed {
    logic [15:0] batt;
    logic [15:0] load;
    logic [15:0] chg;
  } meas_s;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_OFF  = 2'b01,
    TS_ONE  = 2'b10
  } test_state_e;
endpackage

// >>> serial_slave.sv
`timescale 1ns/1ps
module serial_slave
  import alarm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [5:0] site,
  input  wire logic [7:0] out_byte,
  input  wire logic [7:0] in_byte,
  input  wire logic       rx232_space,
  input  wire logic       rx485_space,
  output logic            tx232,
  output logic            tx485_d,
  output logic            tx485_oe
);
  logic        rx_busy_q;
  logic [11:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic [19:0] tx_sh_q;
  logic [4:0]  tx_left_q;
  logic [11:0] tx_cnt_q;

  // Merged receive, 1 = space
  wire rx_space = rx232_space | rx485_space;
  wire rx_samp  = rx_busy_q && (rx_cnt_q == 12'h000);
  wire rx_data  = (rx_bit_q != 4'h0) && (rx_bit_q != 4'h9);
  wire rx_last  = rx_samp && (rx_bit_q == 4'h9);
  wire [7:0] my_cmd = SITE_CMD | {2'b00, site};
  wire tx_busy  = (tx_left_q != 5'h00);
  wire addr_hit = rx_last && !rx_space && (rx_sh_q == my_cmd);
  wire tx_step  = tx_busy && (tx_cnt_q == 12'h000);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 12'h000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else if (!rx_busy_q) begin
      rx_busy_q <= rx_space;
      rx_cnt_q  <= 12'(HALF_CYCLES);
      rx_bit_q  <= 4'h0;
    end else if (rx_samp) begin
      rx_cnt_q <= 12'(BIT_CYCLES - 1);
      rx_bit_q <= rx_bit_q + 4'h1;
      if ((rx_bit_q == 4'h0 && !rx_space) || rx_bit_q == 4'h9) begin
        rx_busy_q <= 1'b0;
      end
      if (rx_data) begin
        rx_sh_q <= {~rx_space, rx_sh_q[7:1]};
      end
    end else begin
      rx_cnt_q <= rx_cnt_q - 12'h001;
    end
  end

  // Reply: alarm output byte, then alarm input byte
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tx_sh_q   <= 20'hF_FFFF;
      tx_left_q <= 5'h00;
      tx_cnt_q  <= 12'h000;
    end else if (addr_hit && !tx_busy) begin
      tx_sh_q   <= {1'b1, in_byte, 1'b0, 1'b1, out_byte, 1'b0};
      tx_left_q <= 5'h14;
      tx_cnt_q  <= 12'(BIT_CYCLES - 1);
    end else if (tx_step) begin
      tx_sh_q   <= {1'b1, tx_sh_q[19:1]};
      tx_left_q <= tx_left_q - 5'h01;
      tx_cnt_q  <= 12'(BIT_CYCLES - 1);
    end else if (tx_busy) begin
      tx_cnt_q <= tx_cnt_q - 12'h001;
    end
  end

  // No handshake lines; both ports carry one stream
  assign tx232    = tx_sh_q[0];
  assign tx485_d  = tx_sh_q[0];
  assign tx485_oe = tx_busy;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  bus_quiet_a : assert property (!tx485_oe |-> tx232)
    else $error("Line not idle while driver off");
  same_data_a : assert property (tx232 == tx485_d)
    else $error("Ports carry different data");
  reply_start_a : assert property (
    addr_hit && !tx485_oe |=> tx485_oe && !tx232)
    else $error("No start bit after site match");
  speak_only_a : assert property (
    $rose(tx485_oe) |-> $past(addr_hit))
    else $error("Driver enabled without request");
  reply_c : cover property ($fell(tx485_oe));
endmodule

// >>> serial_master.sv
`timescale 1ns/1ps
module serial_master
  import alarm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic tx232,
  input  wire logic tx485_d,
  input  wire logic tx485_oe,
  output logic      rx232_space,
  output logic      rx485_space
);
  int errs;

  initial begin
    rx232_space = 1'b0;
    rx485_space = 1'b0;
    errs = 0;
  end

  // One port per frame, idle at space level 0; no handshake lines exist
  task automatic send_byte(input logic on485, input logic [7:0] d);
    logic [8:0] f;
    f = {d, 1'b0};
    for (int i = 0; i < 9; i++) begin
      if (on485) rx485_space <= ~f[i];
      else rx232_space <= ~f[i];
      repeat (BIT_CYCLES) @(posedge mclk);
    end
    rx232_space <= 1'b0;
    rx485_space <= 1'b0;
  endtask

  // Mid-bit sampling; both ports must agree and the driver must be on
  task automatic recv_byte(output logic [7:0] d, output logic got);
    int n;
    d = 8'h00;
    got = 1'b0;
    for (n = 0; n < 3 * BIT_CYCLES && tx232 !== 1'b0; n++) @(posedge mclk);
    if (tx232 === 1'b0) begin
      got = 1'b1;
      repeat (HALF_CYCLES) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
        if (tx485_d !== tx232 || tx485_oe !== 1'b1) errs++;
        if (i == 0 && tx232 !== 1'b0) errs++;
        if (i == 9 && tx232 !== 1'b1) errs++;
        if (i > 0 && i < 9) d = {tx232, d[7:1]};
        if (i < 9) repeat (BIT_CYCLES) @(posedge mclk);
      end
    end
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk);
      if (tx485_oe !== 1'b0 || tx232 !== 1'b1) errs++;
    end
  endtask
endmodule

// >>> alarm_monitor_serial_slave_test.sv
`timescale 1ns/1ps
module alarm_monitor_serial_slave_test
  import alarm_pkg::*;
();
  localparam int unsigned TICK = 20;
  logic        mclk;
  logic        nrst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  meas_s       meas;
  logic [15:0] batt_v;
  logic [15:0] load_v;
  logic [15:0] chg_v;
  logic        gen_req;
  logic [3:0]  reg_bank;
  logic [6:0]  alarm_open;
  logic        rx232_space;
  logic        rx485_space;
  logic        tx232;
  logic        tx485_d;
  logic        tx485_oe;
  logic [3:0]  bank_on;
  logic        test_busy;
  logic [5:0]  relay_on;
  logic [5:0]  alarm_led;
  logic [6:0]  input_led;
  logic [63:0] cur;
  logic [15:0] leak;
  logic [31:0] q;
  logic [7:0]  b;
  logic        got;
  logic        last;
  int          failures;
  int          n_compared;
  // Address and expected read value
  logic [39:0] reg_t [5] = '{40'h04_0000_0000, 40'h08_0000_12C0,
    40'h0C_0000_170C, 40'h10_0000_15E0, 40'h18_0000_0000};
  // Battery, load, expected alarm bits
  logic [47:0] bat_t [13] = '{48'h1270_1270_0000, 48'h126F_126F_0001,
    48'h1297_1297_0001, 48'h1298_1298_0000, 48'h175C_175C_0000,
    48'h175D_175D_0002, 48'h1608_1608_0002, 48'h1607_1607_0000,
    48'h1324_125C_0000, 48'h1324_125B_0010, 48'h1388_12BF_0000,
    48'h1388_0C7F_0010, 48'h1388_0C80_0000};
  // Per-bank currents, current seen with all banks off
  logic [79:0] bk_t [5] = '{80'h012C_012C_012C_012C_0000,
    80'h012C_012C_003C_012C_0000, 80'h012C_012C_003D_012C_01C2,
    80'h012C_012C_012C_012C_01C3, 80'h0000_0000_0000_0384_0000};
  logic [4:0]  bk_fail = 5'b01010;

  assign meas = {batt_v, load_v, chg_v};

  alarm_monitor #(.TICK_LEN(TICK)) uut (.mclk(mclk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .meas(meas),
    .gen_req(gen_req), .reg_bank(reg_bank), .alarm_open(alarm_open),
    .rx232_space(rx232_space), .rx485_space(rx485_space), .tx232(tx232),
    .tx485_d(tx485_d), .tx485_oe(tx485_oe), .bank_on(bank_on),
    .test_busy(test_busy), .relay_on(relay_on), .alarm_led(alarm_led),
    .input_led(input_led));

  serial_master m (.mclk(mclk), .tx232(tx232), .tx485_d(tx485_d),
    .tx485_oe(tx485_oe), .rx232_space(rx232_space),
    .rx485_space(rx485_space));

  // Charge current follows the banks that are switched on
  always @(posedge mclk) begin
    logic [15:0] s;
    s = (bank_on == 4'h0) ? leak : 16'h0000;
    for (int i = 0; i < 4; i++) if (bank_on[i]) s = s + cur[i*16 +: 16];
    chg_v <= s;
  end

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic timeout(input string s);
    failures++;
    $display("mismatch at %0t: timeout in %s", $time, s);
    final_report();
  endtask

  task automatic check(input logic ok, input string s);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    r = readdata;
    if (i == 16) timeout("bus");
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_busy(input logic lvl, input int n);
    int i;
    for (i = 0; i < n && test_busy !== lvl; i++) @(posedge mclk);
    if (i == n) timeout("bank test");
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (110000) @(posedge mclk);
    timeout("run");
  end

  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    batt_v = 16'h1324;
    load_v = 16'h1324;
    gen_req = 1'b0;
    reg_bank = 4'hF;
    alarm_open = 7'h00;
    cur = 64'h012C_012C_012C_012C;
    leak = 16'h0000;
    last = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (6) @(posedge mclk);
    check(relay_on === 6'h3F && alarm_led === 6'h08, "reset alarms");
    check(tx485_oe === 1'b0 && tx232 === 1'b1, "reset port");
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, reg_t[i][39:32], 32'h0000_0000, q);
      check(q === reg_t[i][31:0], "register reset value");
    end
    bus(1'b1, REG_SITE, 32'hFFFF_FFFF, q);
    bus(1'b0, REG_SITE, 32'h0000_0000, q);
    check(q === 32'h0000_003F, "site width");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      alarm_open <= 7'h01 << i;
      bus(1'b0, REG_STATUS, 32'h0000_0000, q);
      check(input_led === 7'h01 << i, "input lamp");
      check(q[14:8] === 7'h01 << i, "input byte");
    end
    $display("test inputs done");
    for (int i = 0; i < 13; i++) begin
      @(posedge mclk);
      batt_v <= bat_t[i][47:32];
      load_v <= bat_t[i][31:16];
      repeat (3) @(posedge mclk);
      check((relay_on & 6'h13) === (~bat_t[i][5:0] & 6'h13), "relay");
      check((alarm_led & 6'h13) === bat_t[i][5:0], "lamp");
    end
    $display("test levels done");
    bus(1'b1, REG_CTRL, 32'h0000_0001, q);
    repeat (3) @(posedge mclk);
    check(relay_on[3] === 1'b1 && alarm_led[3] === 1'b1, "healthy");
    repeat (6 * TICK) @(posedge mclk);
    check(relay_on[3] === 1'b0 && alarm_led[3] === 1'b0, "no refresh");
    $display("test logic fail done");
    for (int r = 0; r < 5; r++) begin
      @(posedge mclk);
      cur <= bk_t[r][79:16];
      leak <= bk_t[r][15:0];
      bus(1'b1, REG_CTRL, 32'h0000_0002, q);
      wait_busy(1'b1, 50);
      check(relay_on[5] === ~last, "result held");
      last = bk_fail[r];
      repeat (2) @(posedge mclk);
      check(bank_on === 4'h0, "all banks off");
      wait_busy(1'b0, 2000);
      repeat (2) @(posedge mclk);
      check(relay_on[5] === ~last && alarm_led[5] === last, "bank");
      check(bank_on === reg_bank, "control returned");
    end
    $display("test bank done");
    gen_req <= 1'b1;
    alarm_open <= 7'h2B;
    bus(1'b1, REG_SITE, 32'h0000_0015, q);
    m.send_byte(1'b1, SITE_CMD | 8'h14);
    m.quiet(3 * BIT_CYCLES);
    m.send_byte(1'b0, SITE_CMD | 8'h15);
    m.recv_byte(b, got);
    check(got === 1'b1 && b === 8'h0C, "reply alarms");
    m.recv_byte(b, got);
    check(got === 1'b1 && b === 8'h2B, "reply inputs");
    repeat (BIT_CYCLES) @(posedge mclk);
    check(tx485_oe === 1'b0, "driver released");
    check(m.errs === 0, "wire");
    $display("test serial done");
    final_report();
  end
endmodule
